// *** conditional_skip_branch_unit.sv ***
// next-address logic for conditional skip and relative branch instructions
// Summary of operation
// - register bit set: skip next instruction, pc plus 2 or 3, 1-3 cycles
// - io register bit clear: skip next instruction, else sequential
// - io register bit set: skip next instruction, 1-3 cycles
// - selected flag set: pc becomes pc plus offset plus one, 1-2 cycles
// - selected flag clear: pc becomes pc plus offset plus one
// - carry clear branch jumps only when carry is zero
// - same-or-higher branch shares the carry-clear condition
// - half-carry set and clear branches jump on that flag
// - transfer-set branch jumps when transfer flag is one
// - transfer-clear branch jumps when transfer flag is zero
// - signed greater-or-equal jumps when negative xor overflow is zero
// - signed less-than jumps when negative xor overflow is one
module conditional_skip_branch_unit
    import skip_branch_pkg::*;
#(
    parameter int PC_W = 12
) (
    input  wire              clk,
    input  wire              rst,
    input  wire              ce,
    input  wire              instr_valid,
    input  op_t              op,
    input  wire  [2:0]       bit_sel,
    input  wire  [7:0]       reg_val,
    input  wire  [7:0]       io_val,
    input  wire  [7:0]       status_flags,
    input  wire  [6:0]       offset,
    input  wire              next_is_two_word,
    output logic [PC_W-1:0]  program_counter,
    output logic [7:0]       flags_out,
    output logic             busy,
    output logic             done,
    output logic             taken
);
    if (PC_W < OFFSET_W + 1 || PC_W > 22) begin : g_bad_width
        $error("PC_W out of range");
    end

    typedef enum logic { st_idle, st_exec } state_t;

    state_t          state_q;
    logic [1:0]      remain_q;
    logic            cond;
    logic            accept;
    logic [PC_W-1:0] next_pc;
    logic [1:0]      cycles;

    function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] pc,
                                               input logic [PC_W-1:0] inc);
        return PC_W'(pc + inc);
    endfunction

    skip_cond_eval u_cond (
        .op           (op),
        .bit_sel      (bit_sel),
        .reg_val      (reg_val),
        .io_val       (io_val),
        .status_flags (status_flags),
        .cond         (cond)
    );

    // a new instruction is only taken while no multi-cycle one is pending
    assign accept = ce && instr_valid && (state_q == st_idle);

    always_comb begin
        next_pc = pc_add(program_counter, PC_W'(1));
        cycles  = 2'(CYC_NOT_TAKEN);
        if (cond && is_skip(op)) begin
            // two-word follower needs one more word and one more cycle
            if (next_is_two_word) begin
                next_pc = pc_add(program_counter, PC_W'(SKIP_TWO_WORDS));
                cycles  = 2'(CYC_SKIP_TWO);
            end else begin
                next_pc = pc_add(program_counter, PC_W'(SKIP_ONE_WORDS));
                cycles  = 2'(CYC_SKIP_ONE);
            end
        end else if (cond && is_branch(op)) begin
            // offset is signed words, relative to the following word
            next_pc = pc_add(program_counter,
                      PC_W'({{(PC_W-OFFSET_W){offset[6]}}, offset})
                      + PC_W'(1));
            cycles  = 2'(CYC_BRANCH_TAKEN);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            program_counter <= PC_W'(PC_RESET_VAL);
        end else if (accept) begin
            program_counter <= next_pc;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q  <= st_idle;
            remain_q <= 2'h0;
            busy     <= 1'b0;
            done     <= 1'b0;
            taken    <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            case (state_q)
                st_idle: begin
                    if (accept) begin
                        taken <= cond && (op != op_other);
                        if (cycles == 2'(CYC_NOT_TAKEN)) begin
                            done <= 1'b1;
                        end else begin
                            state_q  <= st_exec;
                            busy     <= 1'b1;
                            remain_q <= cycles - 2'h1;
                        end
                    end
                end
                st_exec: begin
                    if (remain_q == 2'h1) begin
                        state_q <= st_idle;
                        busy    <= 1'b0;
                        done    <= 1'b1;
                    end
                    remain_q <= remain_q - 2'h1;
                end
                default: begin
                    state_q <= st_idle;
                    busy    <= 1'b0;
                end
            endcase
        end
    end

    // flags only ever mirrored, never written by this block
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_out <= 8'h00;
        end else if (ce) begin
            flags_out <= status_flags;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_skip_reg_set: assert property (
        accept && op == op_skip_reg_bit_set && reg_val[bit_sel]
        && !next_is_two_word
        |=> program_counter == PC_W'($past(program_counter) + 2))
        else $error("register-bit skip did not add two");
    a_skip_io_clear: assert property (
        accept && op == op_skip_io_bit_clear && io_val[bit_sel]
        |=> program_counter == PC_W'($past(program_counter) + 1))
        else $error("io-bit-clear skip taken on set bit");
    a_skip_io_two: assert property (
        accept && op == op_skip_io_bit_set && io_val[bit_sel]
        && next_is_two_word ##1 ce [*2] |-> ##1 done
        && program_counter == PC_W'($past(program_counter, 3) + 3))
        else $error("two-word io skip wrong pc or timing");
    a_branch_flag_time: assert property (
        accept && op == op_branch_flag_set && status_flags[bit_sel]
        ##1 ce |-> ##1 done && taken)
        else $error("taken branch not done in two cycles");
    a_branch_not_taken: assert property (
        accept && op == op_branch_flag_clear && status_flags[bit_sel]
        |=> done && !taken && !busy)
        else $error("untaken branch not one cycle");
    a_carry_clear: assert property (
        accept && op == op_branch_carry_clear && offset == 7'h7F
        && !status_flags[FLAG_C] |=> program_counter == $past(program_counter))
        else $error("carry-clear branch by minus one wrong");
    a_signed_lt: assert property (
        accept && op == op_branch_signed_lt
        |=> taken == ($past(status_flags[FLAG_N]) ^ $past(status_flags[FLAG_V])))
        else $error("signed less-than condition wrong");
    a_flags_kept: assert property (
        ce && !$past(rst) |=> flags_out == $past(status_flags))
        else $error("status flags altered");

    c_skip_two: cover property (accept && is_skip(op) && cond && next_is_two_word);
    c_branch_back: cover property (accept && is_branch(op) && cond && offset[6]);
    c_not_taken: cover property (accept && is_branch(op) && !cond);
endmodule

// *** skip_cond_eval.sv ***
// shared constants and the branch/skip condition evaluator
package skip_branch_pkg;
    localparam int FLAG_C   = 0;
    localparam int FLAG_Z   = 1;
    localparam int FLAG_N   = 2;
    localparam int FLAG_V   = 3;
    localparam int FLAG_S   = 4;
    localparam int FLAG_H   = 5;
    localparam int FLAG_T   = 6;
    localparam int FLAG_I   = 7;
    localparam int PC_RESET_VAL     = 0;
    localparam int OFFSET_W         = 7;
    localparam int CYC_NOT_TAKEN    = 1;
    localparam int CYC_BRANCH_TAKEN = 2;
    localparam int CYC_SKIP_ONE     = 2;
    localparam int CYC_SKIP_TWO     = 3;
    localparam int SKIP_ONE_WORDS   = 2;
    localparam int SKIP_TWO_WORDS   = 3;

    typedef enum logic [4:0] {
        op_other,
        op_skip_reg_bit_clear,
        op_skip_reg_bit_set,
        op_skip_io_bit_clear,
        op_skip_io_bit_set,
        op_branch_flag_set,
        op_branch_flag_clear,
        op_branch_zero_set,
        op_branch_zero_clear,
        op_branch_carry_set,
        op_branch_carry_clear,
        op_branch_same_or_higher,
        op_branch_unsigned_lower,
        op_branch_negative,
        op_branch_positive,
        op_branch_signed_ge,
        op_branch_signed_lt,
        op_branch_halfcarry_set,
        op_branch_halfcarry_clear,
        op_branch_transfer_set,
        op_branch_transfer_clear,
        op_branch_overflow_set
    } op_t;

    function automatic logic is_skip(input op_t op);
        return op inside {op_skip_reg_bit_clear, op_skip_reg_bit_set,
                          op_skip_io_bit_clear, op_skip_io_bit_set};
    endfunction

    function automatic logic is_branch(input op_t op);
        return (op != op_other) && !is_skip(op);
    endfunction
endpackage

module skip_cond_eval
    import skip_branch_pkg::*;
(
    input  op_t        op,
    input  wire  [2:0] bit_sel,
    input  wire  [7:0] reg_val,
    input  wire  [7:0] io_val,
    input  wire  [7:0] status_flags,
    output logic       cond
);
    logic sel_reg;
    logic sel_io;
    logic sel_flag;
    logic sign_lt;

    always_comb begin
        sel_reg  = reg_val[bit_sel];
        sel_io   = io_val[bit_sel];
        sel_flag = status_flags[bit_sel];
        sign_lt  = status_flags[FLAG_N] ^ status_flags[FLAG_V];
        case (op)
            // skip_reg_bit_clear kept for completeness: bit clear
            op_skip_reg_bit_clear:     cond = !sel_reg;
            op_skip_reg_bit_set:       cond = sel_reg;
            op_skip_io_bit_clear:      cond = !sel_io;
            op_skip_io_bit_set:        cond = sel_io;
            op_branch_flag_set:        cond = sel_flag;
            op_branch_flag_clear:      cond = !sel_flag;
            op_branch_zero_set:        cond = status_flags[FLAG_Z];
            op_branch_zero_clear:      cond = !status_flags[FLAG_Z];
            op_branch_carry_set,
            op_branch_unsigned_lower:  cond = status_flags[FLAG_C];
            op_branch_carry_clear:     cond = !status_flags[FLAG_C];
            op_branch_same_or_higher:  cond = !status_flags[FLAG_C];
            op_branch_negative:        cond = status_flags[FLAG_N];
            op_branch_positive:        cond = !status_flags[FLAG_N];
            op_branch_signed_ge:       cond = !sign_lt;
            op_branch_signed_lt:       cond = sign_lt;
            op_branch_halfcarry_set:   cond = status_flags[FLAG_H];
            op_branch_halfcarry_clear: cond = !status_flags[FLAG_H];
            op_branch_transfer_set:    cond = status_flags[FLAG_T];
            op_branch_transfer_clear:  cond = !status_flags[FLAG_T];
            op_branch_overflow_set:    cond = status_flags[FLAG_V];
            default:                   cond = 1'b0;
        endcase
    end
endmodule

// *** tb.sv ***
// self-checking bench for the conditional skip and branch unit
module tb
    import skip_branch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC_W = 12;

    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            ce = 1'b1;
    logic            instr_valid = 1'b0;
    op_t             op = op_other;
    logic [2:0]      bit_sel = 3'h0;
    logic [7:0]      reg_val = 8'h00;
    logic [7:0]      io_val = 8'h00;
    logic [7:0]      status_flags = 8'h00;
    logic [6:0]      offset = 7'h00;
    logic            next_is_two_word = 1'b0;
    logic [PC_W-1:0] program_counter;
    logic [7:0]      flags_out;
    logic            busy;
    logic            done;
    logic            taken;
    int              num_errors = 0;
    int              samples_checked = 0;

    always #50 clk = ~clk;

    conditional_skip_branch_unit #(.PC_W(PC_W)) i_dut (
        .clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
        .op(op), .bit_sel(bit_sel), .reg_val(reg_val), .io_val(io_val),
        .status_flags(status_flags), .offset(offset),
        .next_is_two_word(next_is_two_word),
        .program_counter(program_counter), .flags_out(flags_out),
        .busy(busy), .done(done), .taken(taken));

    task automatic finish_test;
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp,
                           input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // reference condition, written apart from the design's evaluator
    function automatic logic cond_of(op_t o, logic [2:0] b, logic [7:0] r,
                                     logic [7:0] p, logic [7:0] f);
        case (o)
            op_skip_reg_bit_clear:     return !r[b];
            op_skip_reg_bit_set:       return r[b];
            op_skip_io_bit_clear:      return !p[b];
            op_skip_io_bit_set:        return p[b];
            op_branch_flag_set:        return f[b];
            op_branch_flag_clear:      return !f[b];
            op_branch_zero_set:        return f[FLAG_Z];
            op_branch_zero_clear:      return !f[FLAG_Z];
            op_branch_carry_set:       return f[FLAG_C];
            op_branch_unsigned_lower:  return f[FLAG_C];
            op_branch_carry_clear:     return !f[FLAG_C];
            op_branch_same_or_higher:  return !f[FLAG_C];
            op_branch_negative:        return f[FLAG_N];
            op_branch_positive:        return !f[FLAG_N];
            op_branch_signed_ge:       return !(f[FLAG_N] ^ f[FLAG_V]);
            op_branch_signed_lt:       return f[FLAG_N] ^ f[FLAG_V];
            op_branch_halfcarry_set:   return f[FLAG_H];
            op_branch_halfcarry_clear: return !f[FLAG_H];
            op_branch_transfer_set:    return f[FLAG_T];
            op_branch_transfer_clear:  return !f[FLAG_T];
            op_branch_overflow_set:    return f[FLAG_V];
            default:                   return 1'b0;
        endcase
    endfunction

    // one instruction, judged on pc, taken, cycle count and flags
    task automatic exec(input op_t o, input logic [2:0] b, input logic [7:0] r,
                        input logic [7:0] p, input logic [7:0] f,
                        input logic [6:0] k, input logic tw);
        logic [PC_W-1:0] pc_e;
        logic            c;
        int              n;
        int              n_e;
        int              nb;
        @(posedge clk);
        op <= o;
        bit_sel <= b;
        reg_val <= r;
        io_val <= p;
        status_flags <= f;
        offset <= k;
        next_is_two_word <= tw;
        instr_valid <= 1'b1;
        c = cond_of(o, b, r, p, f);
        pc_e = program_counter + 1'b1;
        n_e = CYC_NOT_TAKEN;
        if (c && is_skip(o)) begin
            pc_e = program_counter
                   + PC_W'(tw ? SKIP_TWO_WORDS : SKIP_ONE_WORDS);
            n_e = tw ? CYC_SKIP_TWO : CYC_SKIP_ONE;
        end else if (c) begin
            pc_e = program_counter + {{(PC_W-7){k[6]}}, k} + 1'b1;
            n_e = CYC_BRANCH_TAKEN;
        end
        @(posedge clk);
        instr_valid <= 1'b0;
        #1 n = 1;
        nb = 0;
        while (done !== 1'b1 && n < 8) begin
            if (busy === 1'b1) nb++;
            @(posedge clk);
            #1 n++;
        end
        if (done !== 1'b1) begin
            num_errors++;
            finish_test();
        end
        cmp_val(16'(program_counter), 16'(pc_e), "pc");
        cmp_val(16'(taken), 16'(c), "taken");
        cmp_val(16'(n), 16'(n_e), "cycles");
        cmp_val(16'(nb), 16'(n_e - 1), "busy cycles");
        cmp_val(16'(busy), 16'h0000, "busy at done");
        cmp_val(16'(flags_out), 16'(f), "flags");
    endtask

    task automatic test_reset;
        cmp_val(16'(program_counter), 16'h0000, "reset pc");
        cmp_val(16'({busy, done, taken}), 16'h0000, "reset status");
        cmp_val(16'(flags_out), 16'h0000, "reset flags");
    endtask

    // both bit values, one- and two-word followers
    task automatic test_skips;
        for (int i = 1; i <= 4; i++)
            for (int j = 0; j < 4; j++)
                exec(op_t'(i), 3'(2 * j + i), 8'hA5, 8'h5A, 8'h00, 7'h00,
                     j[0]);
    endtask

    // every branch kind against flag patterns, offsets at both extremes
    task automatic test_branches;
        logic [7:0] pat [5] = '{8'h00, 8'hFF, 8'h04, 8'h08, 8'h61};
        logic [6:0] ofs [5] = '{7'h7F, 7'h7D, 7'h40, 7'h3F, 7'h05};
        for (int i = op_branch_flag_set; i <= op_branch_overflow_set; i++)
            for (int j = 0; j < 5; j++)
                exec(op_t'(i), 3'(i + j), 8'h00, 8'h00, pat[j],
                     ofs[j],
                     1'b0);
    endtask

    // ce low must freeze everything even with a request present
    task automatic test_ce_hold;
        logic [PC_W-1:0] pc0;
        @(posedge clk);
        pc0 = program_counter;
        ce <= 1'b0;
        op <= op_branch_zero_set;
        status_flags <= 8'hFF;
        offset <= 7'h10;
        instr_valid <= 1'b1;
        repeat (3) @(posedge clk);
        #1 cmp_val(16'(program_counter), 16'(pc0), "frozen pc");
        cmp_val(16'({busy, done}), 16'h0000, "frozen status");
        @(posedge clk);
        instr_valid <= 1'b0;
        ce <= 1'b1;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 test_reset();
        exec(op_other, 3'h0, 8'h00, 8'h00, 8'h3C, 7'h00, 1'b0);
        exec(op_other, 3'h0, 8'h00, 8'h00, 8'h3C, 7'h00, 1'b1);
        test_skips();
        test_branches();
        test_ce_hold();
        exec(op_branch_carry_set, 3'h0, 8'h00, 8'h00, 8'h01, 7'h02,
             1'b0);
        finish_test();
    end
endmodule
